// [core/rx_link_pkg.sv]
// Constants, field layouts and carrier types of the serial receiver.
// Assumes one bit-rate clock recovered from the line; no other domain.
//
// Notes on behaviour
// - Bits shift in each bit clock; every ten bits the symbol enters decode.
// - A seen K28.5 comma restarts the bit counter, fixing the byte boundary.
// - With reframe enable low, commas never realign the bit counter.
// - After reframe enable rises, ready waits for a comma; data still flows.
// - Encoded mode: a valid data symbol gives its byte, special flag low.
// - Encoded mode: a valid special symbol gives its code, special flag high.
// - A sent violation symbol is flagged just like a line error.
// - Bypass mode copies the decode register onto all ten output bits.
// - The framer works in bypass mode exactly as in encoded mode.
// - All ten outputs change together, aligned with ready and byte clock.
// - Ready pulses low once per strobed byte, low for six of ten bit times.
// - Encoded mode: ready stays high for pad bytes, telling the sink to ignore them.
// - Encoded mode: comma followed by comma is fill: no ready, outputs show its decode.
// - Comma followed by any other symbol is strobed as usable data.
// - Bypass with reframe enable high strobes once per comma received.
// - Reframe enable is sampled at the falling edge of the byte clock.
// - Mode low decodes 8B/10B; mode high selects bypass.

package rx_link_pkg;

   // ------------------------------------------------------------
   // Framing and timing counts, in bit times
   // ------------------------------------------------------------
   localparam logic [3:0] LAST_BIT = 4'h9;
   localparam logic [3:0] BYTE_CLK_HIGH_BITS = 4'h5;
   localparam logic [3:0] READY_LOW_BITS = 4'h6;
   localparam logic [3:0] RF_SAMPLE_BIT = 4'h4;

   // ------------------------------------------------------------
   // Symbol patterns and decoded codes
   // ------------------------------------------------------------
   localparam logic [9:0] COMMA_NEG = 10'h0fa;
   localparam logic [9:0] COMMA_POS = 10'h305;
   localparam logic [5:0] K28_NEG6 = 6'h0f;
   localparam logic [5:0] K28_POS6 = 6'h30;
   localparam logic [7:0] VIOLATION_SYMBOL_CODE = 8'he0;
   localparam logic [7:0] COMMA_RD_POS_ERR_CODE = 8'he1;
   localparam logic [7:0] COMMA_RD_NEG_ERR_CODE = 8'he2;
   localparam logic [7:0] WRONG_RD_CODE = 8'he4;
   localparam logic [7:0] COMMA_DECODED_CODE = 8'h05;

   // ------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam int CTRL_REFRAME_BIT = 0;
   localparam int CTRL_BYPASS_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int STAT_RF_BIT = 0;
   localparam int STAT_SEARCH_BIT = 1;
   localparam int STAT_VIOL_BIT = 2;
   localparam int STAT_RD_BIT = 3;

   typedef struct packed {
      logic violation;
      logic special;
      logic [7:0] data;
   } rx_word_t;

   typedef struct packed {
      rx_word_t word;
      logic rd;
   } dec_t;

endpackage

// [core/rx_framer_decoder.sv]
// Receiver framer, 8B/10B decoder and parallel output stage.
// Assumes serial_in is already retimed onto the recovered bit clock clk_in;
// control and status sit behind an Avalon-MM slave on the same clock.

`timescale 1ns/100ps

module rx_framer_decoder (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic serial_in,
   input wire logic [3:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   output rx_link_pkg::rx_word_t parallel_word_out,
   output logic ready_n_out,
   output logic recovered_byte_clock_out
);

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic is_comma(input logic [9:0] s);
      return s == rx_link_pkg::COMMA_NEG || s == rx_link_pkg::COMMA_POS;
   endfunction

   // Returns {valid, x}
   function automatic logic [5:0] dec6(input logic [5:0] c);
      case (c)
         6'h27, 6'h18: dec6 = 6'h20;
         6'h1d, 6'h22: dec6 = 6'h21;
         6'h2d, 6'h12: dec6 = 6'h22;
         6'h31: dec6 = 6'h23;
         6'h35, 6'h0a: dec6 = 6'h24;
         6'h29: dec6 = 6'h25;
         6'h19: dec6 = 6'h26;
         6'h38, 6'h07: dec6 = 6'h27;
         6'h39, 6'h06: dec6 = 6'h28;
         6'h25: dec6 = 6'h29;
         6'h15: dec6 = 6'h2a;
         6'h34: dec6 = 6'h2b;
         6'h0d: dec6 = 6'h2c;
         6'h2c: dec6 = 6'h2d;
         6'h1c: dec6 = 6'h2e;
         6'h17, 6'h28: dec6 = 6'h2f;
         6'h1b, 6'h24: dec6 = 6'h30;
         6'h23: dec6 = 6'h31;
         6'h13: dec6 = 6'h32;
         6'h32: dec6 = 6'h33;
         6'h0b: dec6 = 6'h34;
         6'h2a: dec6 = 6'h35;
         6'h1a: dec6 = 6'h36;
         6'h3a, 6'h05: dec6 = 6'h37;
         6'h33, 6'h0c: dec6 = 6'h38;
         6'h26: dec6 = 6'h39;
         6'h16: dec6 = 6'h3a;
         6'h36, 6'h09: dec6 = 6'h3b;
         6'h0e, 6'h0f, 6'h30: dec6 = 6'h3c;
         6'h2e, 6'h11: dec6 = 6'h3d;
         6'h1e, 6'h21: dec6 = 6'h3e;
         6'h2b, 6'h14: dec6 = 6'h3f;
         default: dec6 = 6'h00;
      endcase
   endfunction

   // Returns {valid, y}
   function automatic logic [3:0] dec4(input logic [3:0] c);
      case (c)
         4'hb, 4'h4: dec4 = 4'h8;
         4'h9: dec4 = 4'h9;
         4'h5: dec4 = 4'ha;
         4'hc, 4'h3: dec4 = 4'hb;
         4'hd, 4'h2: dec4 = 4'hc;
         4'ha: dec4 = 4'hd;
         4'h6: dec4 = 4'he;
         4'he, 4'h1, 4'h7, 4'h8: dec4 = 4'hf;
         default: dec4 = 4'h0;
      endcase
   endfunction

   function automatic rx_link_pkg::dec_t decode(input logic [9:0] s,
                                                input logic cur_rd);
      logic [5:0] r6;
      logic [3:0] r4;
      logic [2:0] o6;
      logic [2:0] o4;
      logic k28;
      logic kx7;
      logic rd_mid;
      logic rd_err;
      logic valid;
      rx_link_pkg::dec_t res;
      r6 = dec6(s[9:4]);
      k28 = s[9:4] == rx_link_pkg::K28_NEG6 || s[9:4] == rx_link_pkg::K28_POS6;
      // K28 on positive disparity carries an inverted 4b block
      r4 = dec4(s[9:4] == rx_link_pkg::K28_POS6 ? ~s[3:0] : s[3:0]);
      o6 = 3'($countones(s[9:4]));
      o4 = 3'($countones(s[3:0]));
      kx7 = (s[3:0] == 4'h7 || s[3:0] == 4'h8) &&
            (r6[4:0] == 5'h17 || r6[4:0] == 5'h1b ||
             r6[4:0] == 5'h1d || r6[4:0] == 5'h1e);
      valid = r6[5] && r4[3] && o6 >= 3'h2 && o6 <= 3'h4 &&
              o4 >= 3'h1 && o4 <= 3'h3;
      rd_mid = (o6 == 3'h3) ? cur_rd : (o6 > 3'h3);
      rd_err = (o6 > 3'h3 && cur_rd) || (o6 < 3'h3 && !cur_rd) ||
               (o4 > 3'h2 && rd_mid) || (o4 < 3'h2 && !rd_mid);
      res.rd = (o4 == 3'h2) ? rd_mid : (o4 > 3'h2);
      res.word = '{violation: 1'b1, special: 1'b1,
                   data: rx_link_pkg::VIOLATION_SYMBOL_CODE};
      if (valid && rd_err) begin
         if (is_comma(s)) begin
            res.word.data = cur_rd ? rx_link_pkg::COMMA_RD_POS_ERR_CODE
                                   : rx_link_pkg::COMMA_RD_NEG_ERR_CODE;
         end else begin
            res.word.data = rx_link_pkg::WRONG_RD_CODE;
         end
      end else if (valid && k28) begin
         res.word = '{violation: 1'b0, special: 1'b1,
                      data: {5'h00, r4[2:0]}};
      end else if (valid && kx7) begin
         res.word = '{violation: 1'b0, special: 1'b1,
                      data: 8'h08 + {6'h00, ~(r6[1] & r6[0]),
                                     ~(r6[2] & r6[0])}};
      end else if (valid) begin
         res.word = '{violation: 1'b0, special: 1'b0, data: {r4[2:0], r6[4:0]}};
      end
      return res;
   endfunction

   // ------------------------------------------------------------
   // Register slave
   // ------------------------------------------------------------
   logic [1:0] ctrl;
   logic [1:0] next_ctrl;
   logic rd_pend;
   logic next_rd_pend;
   logic [31:0] next_readdata;
   logic rf_sampled;
   logic searching;
   logic rd;
   rx_link_pkg::rx_word_t out_word;
   logic bypass;

   assign bypass = ctrl[rx_link_pkg::CTRL_BYPASS_BIT];
   assign waitrequest_out = read_in && !rd_pend;

   always_comb begin
      next_ctrl = ctrl;
      next_rd_pend = read_in && !rd_pend;
      next_readdata = readdata_out;
      if (write_in && address_in == rx_link_pkg::ADDR_CTRL &&
          byteenable_in[0]) begin
         next_ctrl = writedata_in[1:0];
      end
      if (read_in && !rd_pend) begin
         next_readdata = 32'h0000_0000;
         case (address_in)
            rx_link_pkg::ADDR_CTRL: next_readdata[1:0] = ctrl;
            rx_link_pkg::ADDR_STATUS: begin
               next_readdata[rx_link_pkg::STAT_RF_BIT] = rf_sampled;
               next_readdata[rx_link_pkg::STAT_SEARCH_BIT] = searching;
               next_readdata[rx_link_pkg::STAT_VIOL_BIT] = out_word.violation;
               next_readdata[rx_link_pkg::STAT_RD_BIT] = rd;
            end
            default: next_readdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl <= rx_link_pkg::CTRL_RESET;
         rd_pend <= 1'b0;
         readdata_out <= 32'h0000_0000;
      end else begin
         ctrl <= next_ctrl;
         rd_pend <= next_rd_pend;
         readdata_out <= next_readdata;
      end
   end

   // ------------------------------------------------------------
   // Shifter, framer, decode and output stage
   // ------------------------------------------------------------
   logic [9:0] shifter;
   logic [9:0] window;
   logic [3:0] bit_cnt;
   logic [9:0] decode_reg;
   logic decode_ok;
   logic strobe;
   logic byte_clk;
   logic comma_hit;
   logic load;
   logic fill;
   rx_link_pkg::dec_t dec;
   logic [9:0] next_shifter;
   logic [3:0] next_bit_cnt;
   logic [9:0] next_decode_reg;
   logic next_decode_ok;
   logic next_strobe;
   logic next_byte_clk;
   logic next_rf_sampled;
   logic next_searching;
   logic next_rd;
   rx_link_pkg::rx_word_t next_out_word;

   assign parallel_word_out = out_word;
   assign recovered_byte_clock_out = byte_clk;
   assign ready_n_out = !(strobe && bit_cnt < rx_link_pkg::READY_LOW_BITS);
   assign window = {shifter[8:0], serial_in};
   assign comma_hit = rf_sampled && is_comma(window);
   assign load = bit_cnt == rx_link_pkg::LAST_BIT || comma_hit;
   assign dec = decode(decode_reg, rd);
   assign fill = is_comma(decode_reg) && is_comma(window);

   always_comb begin
      next_shifter = window;
      next_bit_cnt = load ? 4'h0 : bit_cnt + 4'h1;
      next_rf_sampled = rf_sampled;
      if (bit_cnt == rx_link_pkg::RF_SAMPLE_BIT) begin
         next_rf_sampled = ctrl[rx_link_pkg::CTRL_REFRAME_BIT];
      end
      next_searching = searching;
      if (comma_hit || !next_rf_sampled) begin
         next_searching = 1'b0;
      end else if (!rf_sampled) begin
         next_searching = 1'b1;
      end
      next_decode_reg = decode_reg;
      next_decode_ok = decode_ok;
      next_out_word = out_word;
      next_strobe = strobe;
      next_rd = rd;
      if (load) begin
         next_decode_reg = window;
         next_decode_ok = !searching || comma_hit;
         if (bypass) begin
            next_out_word = rx_link_pkg::rx_word_t'(decode_reg);
            next_strobe = decode_ok &&
                          (!rf_sampled || is_comma(decode_reg));
         end else begin
            next_out_word = dec.word;
            next_rd = dec.rd;
            next_strobe = decode_ok && !fill;
         end
      end
      next_byte_clk = next_bit_cnt < rx_link_pkg::BYTE_CLK_HIGH_BITS;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         shifter <= 10'h000;
         bit_cnt <= 4'h0;
         decode_reg <= 10'h000;
         decode_ok <= 1'b0;
         out_word <= '0;
         strobe <= 1'b0;
         byte_clk <= 1'b1;
         rf_sampled <= 1'b0;
         searching <= 1'b0;
         rd <= 1'b0;
      end else begin
         shifter <= next_shifter;
         bit_cnt <= next_bit_cnt;
         decode_reg <= next_decode_reg;
         decode_ok <= next_decode_ok;
         out_word <= next_out_word;
         strobe <= next_strobe;
         byte_clk <= next_byte_clk;
         rf_sampled <= next_rf_sampled;
         searching <= next_searching;
         rd <= next_rd;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   property p_cnt_wrap;
      bit_cnt == rx_link_pkg::LAST_BIT |=> bit_cnt == 4'h0 && byte_clk;
   endproperty
   a_cnt_wrap: assert property (p_cnt_wrap) else $error("count wrap");

   property p_realign;
      comma_hit |=> bit_cnt == 4'h0 && decode_reg == $past(window);
   endproperty
   a_realign: assert property (p_realign) else $error("realign");

   property p_inhibit;
      !rf_sampled && bit_cnt != rx_link_pkg::LAST_BIT
         |=> bit_cnt == $past(bit_cnt) + 4'h1;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit");

   property p_hold_ready;
      load && !decode_ok |=> !strobe;
   endproperty
   a_hold_ready: assert property (p_hold_ready) else $error("hold");

   property p_data;
      load && !bypass && decode_reg == 10'h2aa
         |=> out_word == 10'h0b5;
   endproperty
   a_data: assert property (p_data) else $error("data decode");

   property p_violation;
      load && !bypass && decode_reg == 10'h3ff
         |=> out_word.violation && out_word.data == 8'he0;
   endproperty
   a_violation: assert property (p_violation) else $error("viol");

   property p_bypass;
      load && bypass |=> out_word == $past(decode_reg);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass");

   property p_ready_shape;
      strobe && bit_cnt == 4'h0 && !rf_sampled && !load
         |-> (!ready_n_out) [*6] ##1 ready_n_out;
   endproperty
   a_ready_shape: assert property (p_ready_shape) else $error("ready");

   property p_fill;
      load && !bypass && fill |=> !strobe;
   endproperty
   a_fill: assert property (p_fill) else $error("fill strobed");

   property p_last_comma;
      load && !bypass && decode_ok && is_comma(decode_reg) && !fill
         |=> strobe;
   endproperty
   a_last_comma: assert property (p_last_comma) else $error("last");

   c_fill: cover property (load && !bypass && fill);
   c_realign: cover property (comma_hit && bit_cnt != rx_link_pkg::LAST_BIT);
   c_bypass_strobe: cover property (bypass && rf_sampled && strobe);

endmodule // rx_framer_decoder

// [test/rx_link_sender.sv]
// Far-end serial sender model: streams ten-bit symbols, first bit a first.
// Assumes the bench queues symbols; an empty queue sends fill commas.

`timescale 1ns/100ps

module rx_link_sender (
   input wire logic clk_in,
   input wire logic rstn_in,
   output logic serial_out
);
   logic [9:0] sym_q[$];
   logic slip_req = 1'b0;
   logic [9:0] cur;
   logic [9:0] nxt;
   logic [3:0] idx;
   logic rd;

   // ------------------------------------------------------------
   // Shifter; queue entry zero means a comma of current disparity
   // ------------------------------------------------------------
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         idx <= 4'h0;
         rd <= 1'b1;
         cur <= rx_link_pkg::COMMA_NEG;
         serial_out <= 1'b0;
      end else begin
         serial_out <= (idx > 4'h9) ? ~cur[0] : cur[4'h9 - idx];
         idx <= idx + 4'h1;
         if (idx == 4'h9 && slip_req) begin
            idx <= 4'hf;
            slip_req <= 1'b0;
         end else if (idx == 4'h9 || idx == 4'hf) begin
            idx <= 4'h0;
            nxt = (sym_q.size() != 0) ? sym_q.pop_front() : 10'h000;
            if (nxt == 10'h000) begin
               cur <= rd ? rx_link_pkg::COMMA_POS : rx_link_pkg::COMMA_NEG;
               rd <= ~rd;
            end else
               cur <= nxt;
         end
      end
   end
endmodule // rx_link_sender

// [test/serial_receiver_framer_decoder_bench.sv]
// Self-checking bench for the receiver framer and decoder.
// Assumes the sender model drives the line; the bench owns the bus.

`timescale 1ns/100ps

module serial_receiver_framer_decoder_bench;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [3:0] address_in = 4'h0;
   logic read_in = 1'b0;
   logic write_in = 1'b0;
   logic [31:0] writedata_in = 32'h0000_0000;
   logic [3:0] byteenable_in = 4'hf;
   logic [31:0] readdata_out;
   logic waitrequest_out;
   rx_link_pkg::rx_word_t parallel_word_out;
   logic ready_n_out;
   logic recovered_byte_clock_out;
   logic serial_line;
   rx_link_pkg::rx_word_t strobes[$];
   logic [9:0] words[$];
   logic [9:0] exp_enc[5] = '{10'h105, 10'h0b5, 10'h04a, 10'h105, 10'h0b5};
   int fail_count = 0;
   int n_tests = 0;
   int low_len = 0;
   int hi_len = 0;
   logic mon_on = 1'b0;
   logic rdy_prev = 1'b1;
   logic bc_prev = 1'b1;
   logic [31:0] rd_val;
   logic hit;

   always #2 clk_in = ~clk_in;

   rx_framer_decoder rx_framer_decoder_inst (
      .clk_in(clk_in), .rstn_in(rstn_in), .serial_in(serial_line),
      .address_in(address_in), .read_in(read_in), .write_in(write_in),
      .writedata_in(writedata_in), .byteenable_in(byteenable_in),
      .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
      .parallel_word_out(parallel_word_out), .ready_n_out(ready_n_out),
      .recovered_byte_clock_out(recovered_byte_clock_out));

   rx_link_sender rx_link_sender_inst (
      .clk_in(clk_in), .rstn_in(rstn_in), .serial_out(serial_line));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic end_of_test;
      if (fail_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus_op(input logic wr, input logic [3:0] a,
                         input logic [31:0] d);
      int k;
      logic wait_low;
      @(posedge clk_in);
      address_in <= a;
      writedata_in <= d;
      write_in <= wr;
      read_in <= ~wr;
      for (k = 0; k < 20; k++) begin
         @(negedge clk_in);
         wait_low = (waitrequest_out === 1'b0);
         rd_val = readdata_out;
         @(posedge clk_in);
         if (wait_low) break;
      end
      write_in <= 1'b0;
      read_in <= 1'b0;
      if (k == 20) begin
         fail_count++;
         $display("[FAIL] %0t bus timeout", $time);
         end_of_test();
      end
   endtask

   task automatic settle(input int n);
      repeat (n * 10) @(posedge clk_in);
   endtask

   // Strobed words, byte clock and ready shape, sampled mid-cycle
   always @(negedge clk_in) begin
      if (mon_on && rstn_in) begin
         if (ready_n_out === 1'b0 && rdy_prev === 1'b1) begin
            strobes.push_back(parallel_word_out);
            check({31'h0, recovered_byte_clock_out & ~bc_prev}, 32'h1);
         end
         if (ready_n_out === 1'b1 && rdy_prev === 1'b0)
            check(low_len, 32'(rx_link_pkg::READY_LOW_BITS));
         if (recovered_byte_clock_out === 1'b0 && bc_prev === 1'b1)
            check(hi_len, 32'(rx_link_pkg::BYTE_CLK_HIGH_BITS));
         if (recovered_byte_clock_out === 1'b1 && bc_prev === 1'b0)
            words.push_back(parallel_word_out);
      end
      low_len = (ready_n_out === 1'b0) ? low_len + 1 : 0;
      hi_len = (recovered_byte_clock_out === 1'b1) ? hi_len + 1 : 0;
      rdy_prev = ready_n_out;
      bc_prev = recovered_byte_clock_out;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_in);
      rstn_in <= 1'b1;
      bus_op(1'b0, rx_link_pkg::ADDR_CTRL, 32'h0);
      check(rd_val, 32'h0);
      bus_op(1'b1, 4'h8, 32'h3);
      bus_op(1'b0, 4'h8, 32'h0);
      check(rd_val, 32'h0);
      bus_op(1'b1, rx_link_pkg::ADDR_CTRL, 32'h1);
      bus_op(1'b0, rx_link_pkg::ADDR_CTRL, 32'h0);
      check(rd_val, 32'h1);
      settle(8);
      bus_op(1'b0, rx_link_pkg::ADDR_STATUS, 32'h0);
      check({31'h0, rd_val[rx_link_pkg::STAT_SEARCH_BIT]}, 32'h0);
      strobes.delete();
      mon_on = 1'b1;
      settle(4);
      check(32'(strobes.size()), 32'h0);
      rx_link_sender_inst.sym_q = '{10'h2aa, 10'h155, 10'h000, 10'h000, 10'h2aa};
      settle(12);
      check(32'(strobes.size()), 32'h5);
      for (int i = 0; i < 5; i++)
         check({22'h0, strobes[i]}, {22'h0, exp_enc[i]});
      // Framer inhibited: a bit slip is not repaired
      bus_op(1'b1, rx_link_pkg::ADDR_CTRL, 32'h0);
      settle(2);
      rx_link_sender_inst.slip_req <= 1'b1;
      settle(3);
      strobes.delete();
      settle(6);
      check({31'h0, strobes.size() >= 5}, 32'h1);
      mon_on = 1'b0;
      bus_op(1'b1, rx_link_pkg::ADDR_CTRL, 32'h1);
      settle(8);
      strobes.delete();
      mon_on = 1'b1;
      settle(4);
      check(32'(strobes.size()), 32'h0);
      // Bypass with reframe: raw symbols, strobe only on commas
      bus_op(1'b1, rx_link_pkg::ADDR_CTRL, 32'h3);
      settle(4);
      strobes.delete();
      words.delete();
      rx_link_sender_inst.sym_q.push_back(10'h2aa);
      settle(6);
      hit = 1'b0;
      foreach (words[i]) if (words[i] === 10'h2aa) hit = 1'b1;
      check({31'h0, hit}, 32'h1);
      check({31'h0, strobes.size() >= 3}, 32'h1);
      foreach (strobes[i])
         check({31'h0, strobes[i] === rx_link_pkg::COMMA_NEG ||
                strobes[i] === rx_link_pkg::COMMA_POS}, 32'h1);
      // Encoded again: violation symbol after a comma
      bus_op(1'b1, rx_link_pkg::ADDR_CTRL, 32'h1);
      settle(4);
      strobes.delete();
      rx_link_sender_inst.sym_q = '{10'h3ff, 10'h2aa};
      settle(8);
      check({22'h0, strobes[0]}, 32'h105);
      check({22'h0, strobes[1]}, 32'h3e0);
      check({22'h0, strobes[2]}, 32'h0b5);
      // Second reset in mid-run
      mon_on = 1'b0;
      rstn_in <= 1'b0;
      settle(1);
      rstn_in <= 1'b1;
      bus_op(1'b0, rx_link_pkg::ADDR_CTRL, 32'h0);
      check(rd_val, 32'h0);
      end_of_test();
   end
endmodule // serial_receiver_framer_decoder_bench
